// *** hw/phy_mode_cfg_defines.svh ***
// offsets, field positions, reset values and timing counts of the port phy mode registers
//
// Behaviour
// - bit 13 of power/energy register enables energy-detect power-down; default zero.
// - read-only bit 1 shows line energy; clears after 256ms without energy.
// - energy bit survives soft reset; hardware reset forces it to one.
// - bits 7:5 of special config hold operating mode, read/write, strap default.
// - bits 4:0 hold management address; answer only there; seeds scrambler.
// - any written management address is accepted without uniqueness checking.
// - loader rewrites special config after reset release and on reload.
// - exempt fields reset on reset-control phy reset, keep on soft reset.
// - autonegotiation strap one gives default mode 111b.
// - autoneg strap zero: mode bit2 zero, bit1 speed strap, bit0 duplex strap.
// - all straps sampled and held when chip reset deasserts; held values are defaults.
// - default management address comes from the address-select strap.
// - codes 000 and 001 select 10 Mb/s half and full duplex, no autoneg.
// - code 010 is 100 Mb/s half duplex, carrier sense on transmit and receive.
// - code 011 is 100 Mb/s full duplex, carrier sense on receive only.
// - 110 powers down, 111 autonegotiates all abilities, 100/101 reserved.
`ifndef PHY_MODE_CFG_DEFINES_SVH
`define PHY_MODE_CFG_DEFINES_SVH

`define IDX_PWR_ENERGY     5'h11
`define IDX_SPECIAL_CFG    5'h12

`define EDPD_BIT           13
`define ENERGY_BIT         1
`define RSVD0_BIT          0
`define MODE_MSB           7
`define MODE_LSB           5
`define ADDR_MSB           4
`define ADDR_LSB           0

`define EDPD_RST           1'b0
`define ENERGY_RST         1'b1
`define RSVD0_RST          1'b0
`define MODE_RST           3'h7
`define MODE_AUTONEG       3'h7
`define ADDR_SEL0          5'h01
`define ADDR_SEL1          5'h02

`define CLK_FREQ_KHZ       25000
`define ENERGY_TIMEOUT_MS  256
`define ENERGY_TIMEOUT_CYC (`ENERGY_TIMEOUT_MS * `CLK_FREQ_KHZ)

`endif

// *** hw/phy_mode_cfg_pkg.sv ***
// types of the port phy mode registers
package phy_mode_cfg_pkg;

  typedef enum logic [2:0]
  {
    MODE_10_HD     = 3'b000,
    MODE_10_FD     = 3'b001,
    MODE_100_HD    = 3'b010,
    MODE_100_FD    = 3'b011,
    MODE_RSVD_A    = 3'b100,
    MODE_RSVD_B    = 3'b101,
    MODE_PWR_DOWN  = 3'b110,
    MODE_ALL_CAP   = 3'b111
  } phy_mode_type;

endpackage

// *** hw/phy_mode_config_regs.sv ***
// port phy mode control/status and special configuration registers
`timescale 1ns/100ps
`default_nettype none
`include "phy_mode_cfg_defines.svh"

module phy_mode_config_regs
  import phy_mode_cfg_pkg::*;
#(
  parameter int ENERGY_TIMEOUT_CYC = `ENERGY_TIMEOUT_CYC
)
(
  // clock and chip-level reset
  input  wire logic        CLK,
  input  wire logic        RESET_N,
  // management access
  input  wire logic [4:0]  MGMT_PHY_ADDR,
  input  wire logic [4:0]  MGMT_REG_IDX,
  input  wire logic        MGMT_WR,
  input  wire logic        MGMT_RD,
  input  wire logic [15:0] MGMT_WDATA,
  output var  logic [15:0] MGMT_RDATA,
  output var  logic        MGMT_RD_VALID,
  output logic             MGMT_ADDR_MATCH,
  // eeprom loader
  output var  logic        LOADER_REQ,
  input  wire logic        LOADER_WR,
  input  wire logic [15:0] LOADER_WDATA,
  input  wire logic        RELOAD_CMD,
  // phy resets
  input  wire logic        PHY_RST_CTL,
  input  wire logic        PHY_SOFT_RST,
  // configuration straps
  input  wire logic        AUTONEG_STRAP,
  input  wire logic        SPEED_STRAP,
  input  wire logic        DUPLEX_STRAP,
  input  wire logic        ADDR_SEL_STRAP,
  // line
  input  wire logic        LINE_ENERGY,
  // phy configuration
  output var  logic        EDPD_EN,
  output var  logic        LINE_ENERGY_PRESENT,
  output var  logic        SPEED_100,
  output var  logic        FULL_DUPLEX,
  output var  logic        AUTONEG_EN,
  output var  logic        POWER_DOWN,
  output var  logic        CRS_ON_TX,
  output var  logic        MODE_RESERVED,
  output var  logic [4:0]  SCRAMBLER_SEED
);

  localparam int CW = $clog2(ENERGY_TIMEOUT_CYC + 1);

  // strap-derived default mode
  function automatic logic [2:0] default_mode
  (
    input logic an,
    input logic sp,
    input logic dp
  );
    return an ? `MODE_AUTONEG : {1'b0, sp, dp};
  endfunction

  // strap-derived default address
  function automatic logic [4:0] default_addr
  (
    input logic sel
  );
    return sel ? `ADDR_SEL1 : `ADDR_SEL0;
  endfunction

  logic          taken_ff;
  logic          an_strap_ff;
  logic          sp_strap_ff;
  logic          dp_strap_ff;
  logic          as_strap_ff;
  logic          edpd_ff;
  logic          nxt_edpd;
  logic          rsvd0_ff;
  logic          nxt_rsvd0;
  logic          energy_ff;
  logic          nxt_energy;
  logic [CW-1:0] quiet_cnt_ff;
  logic [CW-1:0] nxt_quiet_cnt;
  logic [2:0]    mode_ff;
  logic [2:0]    nxt_mode;
  logic [4:0]    addr_ff;
  logic [4:0]    nxt_addr;
  logic [15:0]   rdata_ff;
  logic          rd_valid_ff;
  logic          load_req_ff;

  wire           first_cycle;
  wire           addr_hit;
  wire           sel_pwr;
  wire           sel_cfg;
  wire           wr_pwr;
  wire           wr_cfg;
  wire           rd_any;
  wire           quiet_done;
  wire [2:0]     held_mode;
  wire [4:0]     held_addr;
  wire [15:0]    pwr_word;
  wire [15:0]    cfg_word;
  wire [15:0]    rd_word;
  phy_mode_type  mode_sel;

  // straps settle during reset; the first clock after release takes them
  assign first_cycle = !taken_ff;

  // the phy ignores everything not sent to its own address
  assign addr_hit = taken_ff && (MGMT_PHY_ADDR == addr_ff);
  assign MGMT_ADDR_MATCH = addr_hit;

  assign sel_pwr = addr_hit && (MGMT_REG_IDX == `IDX_PWR_ENERGY);
  assign sel_cfg = addr_hit && (MGMT_REG_IDX == `IDX_SPECIAL_CFG);
  assign wr_pwr  = MGMT_WR && sel_pwr;
  assign wr_cfg  = MGMT_WR && sel_cfg;
  assign rd_any  = MGMT_RD && (sel_pwr || sel_cfg);

  assign held_mode = default_mode(an_strap_ff, sp_strap_ff, dp_strap_ff);
  assign held_addr = default_addr(as_strap_ff);

  // reserved read-only positions are constant zero
  assign pwr_word = {2'h0, edpd_ff, 11'h000, energy_ff, rsvd0_ff};
  assign cfg_word = {8'h00, mode_ff, addr_ff};
  assign rd_word  = sel_pwr ? pwr_word : cfg_word;

  assign quiet_done = (quiet_cnt_ff == CW'(ENERGY_TIMEOUT_CYC - 1));

  // strap capture at reset release
  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      taken_ff    <= 1'b0;
      an_strap_ff <= 1'b0;
      sp_strap_ff <= 1'b0;
      dp_strap_ff <= 1'b0;
      as_strap_ff <= 1'b0;
    end
    else if (first_cycle)
    begin
      taken_ff    <= 1'b1;
      an_strap_ff <= AUTONEG_STRAP;
      sp_strap_ff <= SPEED_STRAP;
      dp_strap_ff <= DUPLEX_STRAP;
      as_strap_ff <= ADDR_SEL_STRAP;
    end
  end

  // power and energy control: not exempt, so soft reset clears it
  always_comb
  begin
    nxt_edpd  = edpd_ff;
    nxt_rsvd0 = rsvd0_ff;
    if (PHY_RST_CTL || PHY_SOFT_RST)
    begin
      nxt_edpd  = `EDPD_RST;
      nxt_rsvd0 = `RSVD0_RST;
    end
    else if (wr_pwr)
    begin
      nxt_edpd  = MGMT_WDATA[`EDPD_BIT];
      nxt_rsvd0 = MGMT_WDATA[`RSVD0_BIT];
    end
  end

  // energy presence; the soft reset does not touch it
  always_comb
  begin
    nxt_energy    = energy_ff;
    nxt_quiet_cnt = quiet_cnt_ff;
    if (PHY_RST_CTL)
    begin
      nxt_energy    = `ENERGY_RST;
      nxt_quiet_cnt = '0;
    end
    else if (LINE_ENERGY)
    begin
      nxt_energy    = 1'b1;
      nxt_quiet_cnt = '0;
    end
    else if (energy_ff)
    begin
      if (quiet_done)
      begin
        nxt_energy    = 1'b0;
        nxt_quiet_cnt = '0;
      end
      else
      begin
        nxt_quiet_cnt = quiet_cnt_ff + CW'(1);
      end
    end
  end

  // exempt fields: loader beats host, phy reset beats both
  always_comb
  begin
    nxt_mode = mode_ff;
    nxt_addr = addr_ff;
    if (first_cycle)
    begin
      nxt_mode = default_mode(AUTONEG_STRAP, SPEED_STRAP, DUPLEX_STRAP);
      nxt_addr = default_addr(ADDR_SEL_STRAP);
    end
    else if (PHY_RST_CTL)
    begin
      nxt_mode = held_mode;
      nxt_addr = held_addr;
    end
    else if (LOADER_WR)
    begin
      nxt_mode = LOADER_WDATA[`MODE_MSB:`MODE_LSB];
      nxt_addr = LOADER_WDATA[`ADDR_MSB:`ADDR_LSB];
    end
    else if (wr_cfg)
    begin
      nxt_mode = MGMT_WDATA[`MODE_MSB:`MODE_LSB];
      // no clash check against the other phys; keeping them apart is up to software
      nxt_addr = MGMT_WDATA[`ADDR_MSB:`ADDR_LSB];
    end
  end

  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      edpd_ff      <= `EDPD_RST;
      rsvd0_ff     <= `RSVD0_RST;
      energy_ff    <= `ENERGY_RST;
      quiet_cnt_ff <= '0;
      mode_ff      <= `MODE_RST;
      addr_ff      <= `ADDR_SEL0;
    end
    else
    begin
      edpd_ff      <= nxt_edpd;
      rsvd0_ff     <= nxt_rsvd0;
      energy_ff    <= nxt_energy;
      quiet_cnt_ff <= nxt_quiet_cnt;
      mode_ff      <= nxt_mode;
      addr_ff      <= nxt_addr;
    end
  end

  assign LOADER_REQ = load_req_ff;

  // read answer and loader request, each one cycle after its cause
  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      rdata_ff    <= 16'h0000;
      rd_valid_ff <= 1'b0;
      load_req_ff <= 1'b0;
    end
    else
    begin
      rd_valid_ff <= rd_any;
      load_req_ff <= first_cycle || RELOAD_CMD;
      if (rd_any)
      begin
        rdata_ff <= rd_word;
      end
    end
  end

  assign MGMT_RDATA    = rdata_ff;
  assign MGMT_RD_VALID = rd_valid_ff;

  // operating mode decode
  assign mode_sel = phy_mode_type'(mode_ff);

  logic nxt_speed;
  logic nxt_duplex;
  logic nxt_autoneg;
  logic nxt_pdown;
  logic nxt_crs_tx;
  logic nxt_rsvd_mode;

  always_comb
  begin
    nxt_speed     = 1'b0;
    nxt_duplex    = 1'b0;
    nxt_autoneg   = 1'b0;
    nxt_pdown     = 1'b0;
    nxt_crs_tx    = 1'b0;
    nxt_rsvd_mode = 1'b0;
    unique case (mode_sel)
      MODE_10_HD:
      begin
        nxt_crs_tx = 1'b1;
      end
      MODE_10_FD:
      begin
        nxt_duplex = 1'b1;
      end
      MODE_100_HD:
      begin
        nxt_speed  = 1'b1;
        nxt_crs_tx = 1'b1;
      end
      MODE_100_FD:
      begin
        nxt_speed  = 1'b1;
        nxt_duplex = 1'b1;
      end
      MODE_RSVD_A,
      MODE_RSVD_B:
      begin
        nxt_rsvd_mode = 1'b1;
      end
      MODE_PWR_DOWN:
      begin
        nxt_pdown = 1'b1;
      end
      MODE_ALL_CAP:
      begin
        // advertising everything; speed and duplex follow the negotiation
        nxt_autoneg = 1'b1;
      end
    endcase
  end

  // mode decode outputs cleared to zero by reset, not to the power-up mode's decode, then registered one cycle after the decode
  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      SPEED_100      <= 1'b0;
      FULL_DUPLEX    <= 1'b0;
      AUTONEG_EN     <= 1'b0;
      POWER_DOWN     <= 1'b0;
      CRS_ON_TX      <= 1'b0;
      MODE_RESERVED  <= 1'b0;
      EDPD_EN        <= `EDPD_RST;
      LINE_ENERGY_PRESENT <= `ENERGY_RST;
      SCRAMBLER_SEED <= `ADDR_SEL0;
    end
    else
    begin
      SPEED_100      <= nxt_speed;
      FULL_DUPLEX    <= nxt_duplex;
      AUTONEG_EN     <= nxt_autoneg;
      POWER_DOWN     <= nxt_pdown;
      CRS_ON_TX      <= nxt_crs_tx;
      MODE_RESERVED  <= nxt_rsvd_mode;
      EDPD_EN        <= edpd_ff;
      LINE_ENERGY_PRESENT <= energy_ff;
      SCRAMBLER_SEED <= addr_ff;
    end
  end

endmodule // phy_mode_config_regs

`default_nettype wire

// *** tb/phy_mode_config_regs_properties.sv ***
// concurrent checks on the port phy mode register ports
`timescale 1ns/100ps
`default_nettype none

module phy_mode_config_regs_properties
#(
  parameter int ENERGY_TIMEOUT_CYC = 16
)
(
  // clock and reset
  input wire logic        CLK,
  input wire logic        RESET_N,
  // management access
  input wire logic [4:0]  MGMT_PHY_ADDR,
  input wire logic [4:0]  MGMT_REG_IDX,
  input wire logic        MGMT_RD,
  input wire logic [15:0] MGMT_RDATA,
  input wire logic        MGMT_RD_VALID,
  input wire logic        MGMT_ADDR_MATCH,
  // loader and resets
  input wire logic        LOADER_REQ,
  input wire logic        RELOAD_CMD,
  input wire logic        PHY_RST_CTL,
  // line and status
  input wire logic        LINE_ENERGY,
  input wire logic        EDPD_EN,
  input wire logic        LINE_ENERGY_PRESENT,
  input wire logic [4:0]  SCRAMBLER_SEED
);
  // quiet line cycles; the phy reset restarts it, as it restarts the design's count
  int quiet_ff;

  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
      quiet_ff <= 0;
    else
      quiet_ff <= (LINE_ENERGY || PHY_RST_CTL) ? 0 : quiet_ff + 1;
  end

  default clocking dclk @(posedge CLK); endclocking
  default disable iff (!RESET_N);

  AST_READ_ANSWER: assert property (
    MGMT_RD && MGMT_ADDR_MATCH && MGMT_REG_IDX inside {5'h11, 5'h12} |=> MGMT_RD_VALID)
    else $error("read at own address not answered");
  AST_SEED_IS_ADDR: assert property (
    MGMT_ADDR_MATCH && $past(MGMT_ADDR_MATCH) && $stable(MGMT_PHY_ADDR)
    |-> SCRAMBLER_SEED == MGMT_PHY_ADDR) else $error("scrambler seed differs from address");
  AST_ENERGY_SET: assert property (LINE_ENERGY |-> ##2 LINE_ENERGY_PRESENT)
    else $error("line energy not reported");
  AST_ENERGY_HOLD: assert property (
    $fell(LINE_ENERGY_PRESENT) |-> quiet_ff >= ENERGY_TIMEOUT_CYC + 1)
    else $error("energy flag cleared too early");
  AST_ENERGY_CLEAR: assert property (
    quiet_ff == ENERGY_TIMEOUT_CYC + 1 |-> !LINE_ENERGY_PRESENT)
    else $error("energy flag not cleared after quiet time");
  AST_RSVD_ZERO: assert property (MGMT_RD_VALID |->
    (MGMT_RDATA & ($past(MGMT_REG_IDX) == 5'h11 ? 16'hdffc : 16'hff00)) == 16'h0000)
    else $error("reserved bits read as one");
  AST_STATUS_COPY: assert property (
    MGMT_RD_VALID && $past(MGMT_REG_IDX) == 5'h11
    |-> MGMT_RDATA[13] == EDPD_EN && MGMT_RDATA[1] == LINE_ENERGY_PRESENT)
    else $error("status read differs from outputs");
  AST_RELOAD_REQ: assert property (RELOAD_CMD |=> LOADER_REQ)
    else $error("reload did not request the loader");
  AST_BOOT_LOAD_REQ: assert property ($rose(RESET_N) |=> LOADER_REQ)
    else $error("reset release did not request the loader");

  COV_READ: cover property (MGMT_RD_VALID);
  COV_QUIET: cover property ($fell(LINE_ENERGY_PRESENT));
  COV_LOAD: cover property (LOADER_REQ);
endmodule // phy_mode_config_regs_properties

bind phy_mode_config_regs phy_mode_config_regs_properties
  #(.ENERGY_TIMEOUT_CYC(ENERGY_TIMEOUT_CYC)) props (.*);

`default_nettype wire

// *** tb/eeprom_loader_model.sv ***
// eeprom loader model that rewrites the special configuration word on request
`timescale 1ns/100ps
`default_nettype none

module eeprom_loader_model
#(
  parameter int DELAY = 3
)
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        reset_n,
  // request side
  input  wire logic        load_req,
  input  wire logic        enable,
  input  wire logic [15:0] image,
  // write side
  output logic             load_wr,
  output logic [15:0]      load_data
);
  logic [3:0] wait_ff;

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      wait_ff   <= 4'h0;
      load_wr   <= 1'b0;
      load_data <= 16'hffff;
    end
    else
    begin
      load_wr   <= 1'b0;
      // idle data keeps moving so a stale word is never mistaken for a write
      load_data <= ~load_data;
      if (load_req && enable)
        wait_ff <= 4'(DELAY);
      else if (wait_ff != 4'h0)
        wait_ff <= wait_ff - 4'h1;
      if (wait_ff == 4'h1)
      begin
        load_wr   <= 1'b1;
        load_data <= image;
      end
    end
  end
endmodule // eeprom_loader_model

`default_nettype wire

// *** tb/tb_top.sv ***
// testbench of the port phy mode registers
`timescale 1ns/100ps
`default_nettype none

module tb_top;
  localparam int          T    = 16;
  localparam logic [15:0] NONE = 16'hdead;

  logic        CLK = 1'b0;
  logic        RESET_N = 1'b0;
  logic [4:0]  MGMT_PHY_ADDR = 5'h00;
  logic [4:0]  MGMT_REG_IDX = 5'h00;
  logic        MGMT_WR = 1'b0;
  logic        MGMT_RD = 1'b0;
  logic [15:0] MGMT_WDATA = 16'h0000;
  logic        RELOAD_CMD = 1'b0;
  logic        PHY_RST_CTL = 1'b0;
  logic        PHY_SOFT_RST = 1'b0;
  logic        AUTONEG_STRAP = 1'b0;
  logic        SPEED_STRAP = 1'b1;
  logic        DUPLEX_STRAP = 1'b0;
  logic        ADDR_SEL_STRAP = 1'b1;
  logic        LINE_ENERGY = 1'b1;
  logic        ld_en = 1'b0;
  logic [15:0] MGMT_RDATA, LOADER_WDATA;
  logic        MGMT_RD_VALID, MGMT_ADDR_MATCH, LOADER_REQ, LOADER_WR, EDPD_EN;
  logic        LINE_ENERGY_PRESENT, SPEED_100, FULL_DUPLEX, AUTONEG_EN;
  logic        POWER_DOWN, CRS_ON_TX, MODE_RESERVED;
  logic [4:0]  SCRAMBLER_SEED;
  logic [2:0]  c;
  int          err_count = 0;
  int          num_checks = 0;

  phy_mode_config_regs #(.ENERGY_TIMEOUT_CYC(T)) DUT (.*);

  eeprom_loader_model loader
  (
    .clk       (CLK),
    .reset_n   (RESET_N),
    .load_req  (LOADER_REQ),
    .enable    (ld_en),
    .image     (16'h0023),
    .load_wr   (LOADER_WR),
    .load_data (LOADER_WDATA)
  );

  initial
  begin
    forever #20 CLK = ~CLK;
  end

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [4:0] a, input logic [4:0] i, input logic [15:0] d);
    @(posedge CLK);
    MGMT_PHY_ADDR <= a;
    MGMT_REG_IDX  <= i;
    MGMT_WDATA    <= d;
    MGMT_WR       <= 1'b1;
    @(posedge CLK);
    MGMT_WR <= 1'b0;
  endtask

  // a refused read is expected as NONE
  task automatic rd(input logic [4:0] a, input logic [4:0] i, input logic [15:0] e);
    @(posedge CLK);
    MGMT_PHY_ADDR <= a;
    MGMT_REG_IDX  <= i;
    MGMT_RD       <= 1'b1;
    @(posedge CLK);
    MGMT_RD <= 1'b0;
    @(posedge CLK);
    chk(MGMT_RD_VALID ? MGMT_RDATA : NONE, e);
  endtask

  task automatic results();
    if (err_count == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  initial
  begin
    #40000;
    err_count++;
    results();
  end

  initial
  begin
    repeat (4) @(posedge CLK);
    RESET_N <= 1'b1;
    repeat (2) @(posedge CLK);
    SPEED_STRAP <= 1'b0;
    rd(5'h02, 5'h12, 16'h0042);
    rd(5'h02, 5'h11, 16'h0002);
    rd(5'h01, 5'h12, NONE);
    rd(5'h02, 5'h13, NONE);
    wr(5'h02, 5'h11, 16'hffff);
    rd(5'h02, 5'h11, 16'h2003);
    wr(5'h02, 5'h12, 16'hff02);
    rd(5'h02, 5'h12, 16'h0002);
    @(posedge CLK);
    PHY_SOFT_RST <= 1'b1;
    @(posedge CLK);
    PHY_SOFT_RST <= 1'b0;
    rd(5'h02, 5'h11, 16'h0002);
    rd(5'h02, 5'h12, 16'h0002);
    LINE_ENERGY <= 1'b0;
    repeat (T + 4) @(posedge CLK);
    rd(5'h02, 5'h11, 16'h0000);
    @(posedge CLK);
    PHY_RST_CTL <= 1'b1;
    @(posedge CLK);
    PHY_RST_CTL <= 1'b0;
    rd(5'h02, 5'h12, 16'h0042);
    rd(5'h02, 5'h11, 16'h0002);
    LINE_ENERGY <= 1'b1;
    for (int i = 0; i < 8; i++)
    begin
      c = 3'(i);
      wr(5'h02, 5'h12, {8'h00, c, 5'h02});
      rd(5'h02, 5'h12, {8'h00, c, 5'h02});
      chk({13'h0, AUTONEG_EN, POWER_DOWN, MODE_RESERVED}, {13'h0, c == 3'h7, c == 3'h6, c[2:1] == 2'b10});
      if (!c[2])
        chk({13'h0, SPEED_100, FULL_DUPLEX, CRS_ON_TX}, {13'h0, c[1], c[0], !c[0]});
    end
    RESET_N <= 1'b0;
    AUTONEG_STRAP  <= 1'b1;
    ADDR_SEL_STRAP <= 1'b0;
    repeat (4) @(posedge CLK);
    RESET_N <= 1'b1;
    repeat (2) @(posedge CLK);
    rd(5'h01, 5'h12, 16'h00e1);
    wr(5'h01, 5'h12, 16'h0065);
    rd(5'h05, 5'h12, 16'h0065);
    rd(5'h01, 5'h12, NONE);
    chk({11'h0, SCRAMBLER_SEED}, 16'h0005);
    ld_en <= 1'b1;
    @(posedge CLK);
    RELOAD_CMD <= 1'b1;
    @(posedge CLK);
    RELOAD_CMD <= 1'b0;
    repeat (8) @(posedge CLK);
    rd(5'h03, 5'h12, 16'h0023);
    results();
  end
endmodule // tb_top

`default_nettype wire
